// file: include/ltmc_regs.vh
`ifndef LTMC_REGS_VH
`define LTMC_REGS_VH

// Clock period in ns (10 MHz)
`define LTMC_CLK_NS        100
// Dominant time-out on the transmit input, in us
`define LTMC_DOM_TIMEOUT_US 6000
`define LTMC_DOM_CYC       ((`LTMC_DOM_TIMEOUT_US * 1000) / `LTMC_CLK_NS)
// Recessive time that re-arms the driver after a time-out, in us
`define LTMC_REACT_US      10
`define LTMC_REACT_CYC     ((`LTMC_REACT_US * 1000 + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
// Reset hold after the regulator is good, in us
`define LTMC_RESET_US      4000
`define LTMC_RESET_CYC     ((`LTMC_RESET_US * 1000) / `LTMC_CLK_NS)
// Dominant time that qualifies a wake-up, in us
`define LTMC_WAKE_US       90
`define LTMC_WAKE_CYC      ((`LTMC_WAKE_US * 1000 + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
// Undervoltage falling-edge delay on the reset output, in cycles
`define LTMC_RES_F_CYC     4

// Mode encodings
`define LTMC_MODE_FAILSAFE 3'h0
`define LTMC_MODE_NORMAL   3'h1
`define LTMC_MODE_SILENT   3'h2
`define LTMC_MODE_SLEEP    3'h3
`define LTMC_MODE_UNPOWER  3'h4

`endif

// file: rtl/ltmc_timer.v
`timescale 1ns/10ps
// ==========================================================
// Saturating cycle counter
module ltmc_timer #(
	parameter WIDTH = 16
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             ce,
	input  wire             run,
	output reg  [WIDTH-1:0] count_q
);

	// Counts while run is high, clears otherwise, sticks at the top
	always @(posedge clk) begin
		if (!rst_n) begin
			count_q <= {WIDTH{1'b0}};
		end else if (ce) begin
			if (!run)
				count_q <= {WIDTH{1'b0}};
			else if (count_q != {WIDTH{1'b1}})
				count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule

// file: rtl/ltmc_core.v
`timescale 1ns/10ps
`include "ltmc_regs.vh"
// How it works
// - Battery below 5V blocks any bus transmission.
// - Battery power-up enters Fail-safe with regulator on.
// - Regulator undervoltage drives reset low after a short fixed delay.
// - Reset stays low 4ms after regulator reaches nominal level.
// - Normal mode: transmit low drives bus dominant, high leaves recessive.
// - Transmit low over 6ms forces the driver recessive.
// - After time-out, transmit high over 10us re-enables the driver.
// - Normal: receive output high for recessive bus, low for dominant.
// - Enable high selects Normal mode, both paths active, regulator on.
// - Enable falling with transmit high enters Silent mode.
// - Enable falling with transmit low enters Sleep, regulator off.
// - Undervoltage in Normal or Silent asserts reset and goes Fail-safe.
// - Silent: transmit off, receive high, regulator on.
// - Silent entry does not depend on the bus level.
// - Silent: bus below pre-wake threshold enables receiver and termination.
// - Wake-up is falling edge, dominant over 90us, then rising edge.
// - Wake-up in Silent goes Fail-safe and pulls receive low.
// - After wake-up, enable high moves straight to Normal.
// - Fail-safe keeps bus off until enable high, then Normal.
// - Reset output low forces Fail-safe from any mode except Sleep; battery loss forces Unpower.
// - Mode changes are ignored while the reset delay runs.
module ltmc_core #(
	parameter DOM_CYC   = `LTMC_DOM_CYC,
	parameter RESET_CYC = `LTMC_RESET_CYC
) (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       ce,
	input  wire       txd_in,
	input  wire       en_in,
	input  wire       lin_in,
	input  wire       battery_supply,
	input  wire       battery_low,
	input  wire       vcc_good,
	input  wire       prewake_threshold,
	output reg        lin_drive_q,
	output reg        rxd_out_q,
	output reg        rxd_oe_q,
	output reg        undervoltage_reset_n,
	output reg        vcc_enable_q,
	output reg        termination_on_q,
	output reg        receiver_on_q,
	output reg        wake_flag_q,
	output reg  [2:0] mode_q
);

	// ==========================================================
	// Input synchronisers
	reg [1:0] txd_sync_q;
	reg [1:0] en_sync_q;
	reg [1:0] lin_sync_q;
	reg [1:0] bat_sync_q;
	reg [1:0] blow_sync_q;
	reg [1:0] vgood_sync_q;
	reg [1:0] pw_sync_q;
	reg       en_prev_q;
	reg       lin_prev_q;

	wire txd     = txd_sync_q[1];
	wire en      = en_sync_q[1];
	wire lin     = lin_sync_q[1];
	wire bat     = bat_sync_q[1];
	wire bat_low = blow_sync_q[1];
	wire vgood   = vgood_sync_q[1];
	wire prewake = pw_sync_q[1];

	// Two flops per pin; only the second stage is used below
	always @(posedge clk) begin
		if (!rst_n) begin
			txd_sync_q   <= 2'h3;
			en_sync_q    <= 2'h0;
			lin_sync_q   <= 2'h3;
			bat_sync_q   <= 2'h0;
			blow_sync_q  <= 2'h3;
			vgood_sync_q <= 2'h0;
			pw_sync_q    <= 2'h0;
			en_prev_q    <= 1'b0;
			lin_prev_q   <= 1'b1;
		end else if (ce) begin
			txd_sync_q   <= {txd_sync_q[0], txd_in};
			en_sync_q    <= {en_sync_q[0], en_in};
			lin_sync_q   <= {lin_sync_q[0], lin_in};
			bat_sync_q   <= {bat_sync_q[0], battery_supply};
			blow_sync_q  <= {blow_sync_q[0], battery_low};
			vgood_sync_q <= {vgood_sync_q[0], vcc_good};
			pw_sync_q    <= {pw_sync_q[0], prewake_threshold};
			en_prev_q    <= en;
			lin_prev_q   <= lin;
		end
	end

	wire en_fall  = en_prev_q & ~en;
	wire lin_fall = lin_prev_q & ~lin;
	wire lin_rise = ~lin_prev_q & lin;

	// ==========================================================
	// Timers
	wire [15:0] dom_cnt;
	wire [15:0] react_cnt;
	wire [15:0] res_cnt;
	wire [15:0] wake_cnt;
	wire [15:0] resf_cnt;
	reg         dom_lock_q;
	reg         wake_arm_q;
	reg         res_hold_q;

	// Helper: count reached a threshold
	function reached;
		input [15:0] cnt;
		input [31:0] lim;
		begin
			reached = ({16'h0, cnt} >= lim);
		end
	endfunction

	// Dominant time-out counter watches transmit in every mode
	ltmc_timer #(.WIDTH(16)) u_dom (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.run     (~txd & ~dom_lock_q),
		.count_q (dom_cnt)
	);

	// Recessive time after a time-out
	ltmc_timer #(.WIDTH(16)) u_react (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.run     (txd & dom_lock_q),
		.count_q (react_cnt)
	);

	// Reset hold after the regulator is good
	ltmc_timer #(.WIDTH(16)) u_res (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.run     (res_hold_q & vgood),
		.count_q (res_cnt)
	);

	// Dominant length of a wake-up candidate
	ltmc_timer #(.WIDTH(16)) u_wake (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.run     (wake_arm_q & ~lin),
		.count_q (wake_cnt)
	);

	// Falling-edge delay of the reset output
	ltmc_timer #(.WIDTH(16)) u_resf (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.run     (~vgood & ~res_hold_q),
		.count_q (resf_cnt)
	);

	// Time-out lock: set after 6ms low, cleared after 10us high
	always @(posedge clk) begin
		if (!rst_n) begin
			dom_lock_q <= 1'b0;
		end else if (ce) begin
			if (!dom_lock_q && reached(dom_cnt, DOM_CYC))
				dom_lock_q <= 1'b1;
			else if (dom_lock_q && reached(react_cnt, `LTMC_REACT_CYC))
				dom_lock_q <= 1'b0;
		end
	end

	// Reset hold: entered on regulator dropout, left 4ms after good
	wire uv_event = ~vgood & ~res_hold_q & reached(resf_cnt, `LTMC_RES_F_CYC);
	always @(posedge clk) begin
		if (!rst_n) begin
			res_hold_q <= 1'b1;
		end else if (ce) begin
			if (!bat)
				res_hold_q <= 1'b1;
			else if (uv_event)
				res_hold_q <= 1'b1;
			else if (res_hold_q && reached(res_cnt, RESET_CYC))
				res_hold_q <= 1'b0;
		end
	end

	// ==========================================================
	// Mode machine
	reg [2:0] mode_d;
	wire      wake_req = wake_arm_q & lin_rise & reached(wake_cnt, `LTMC_WAKE_CYC);

	// Wake detector armed on a falling edge in low-power modes
	always @(posedge clk) begin
		if (!rst_n) begin
			wake_arm_q <= 1'b0;
		end else if (ce) begin
			if (mode_q != `LTMC_MODE_SILENT && mode_q != `LTMC_MODE_SLEEP)
				wake_arm_q <= 1'b0;
			else if (lin_fall)
				wake_arm_q <= 1'b1;
			else if (lin_rise)
				wake_arm_q <= 1'b0;
		end
	end

	// Next mode; reset hold blocks requests and forces Fail-safe except from Sleep
	always @* begin
		mode_d = mode_q;
		if (!bat) begin
			mode_d = `LTMC_MODE_UNPOWER;
		end else if (mode_q == `LTMC_MODE_UNPOWER) begin
			mode_d = `LTMC_MODE_FAILSAFE;
		end else if (res_hold_q) begin
			if (mode_q != `LTMC_MODE_SLEEP)
				mode_d = `LTMC_MODE_FAILSAFE;
		end else begin
			case (mode_q)
			`LTMC_MODE_FAILSAFE: begin
				if (en)
					mode_d = `LTMC_MODE_NORMAL;
			end
			`LTMC_MODE_NORMAL: begin
				if (en_fall && txd)
					mode_d = `LTMC_MODE_SILENT;
				else if (en_fall && !txd)
					mode_d = `LTMC_MODE_SLEEP;
			end
			`LTMC_MODE_SILENT: begin
				if (wake_req)
					mode_d = `LTMC_MODE_FAILSAFE;
				else if (en)
					mode_d = `LTMC_MODE_NORMAL;
			end
			`LTMC_MODE_SLEEP: begin
				if (wake_req || en)
					mode_d = `LTMC_MODE_FAILSAFE;
			end
			default: begin
				mode_d = `LTMC_MODE_FAILSAFE;
			end
			endcase
		end
	end

	// Undervoltage in Normal or Silent is caught by res_hold_q above
	always @(posedge clk) begin
		if (!rst_n)
			mode_q <= `LTMC_MODE_UNPOWER;
		else if (ce)
			mode_q <= mode_d;
	end

	// ==========================================================
	// Pin outputs, all registered
	// Wake flag survives until Normal mode or battery loss; set beats clear
	always @(posedge clk) begin
		if (!rst_n) begin
			wake_flag_q <= 1'b0;
		end else if (ce) begin
			if (wake_req)
				wake_flag_q <= 1'b1;
			else if (mode_d == `LTMC_MODE_NORMAL || !bat)
				wake_flag_q <= 1'b0;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			lin_drive_q          <= 1'b0;
			rxd_out_q            <= 1'b1;
			rxd_oe_q             <= 1'b0;
			undervoltage_reset_n <= 1'b0;
			vcc_enable_q         <= 1'b0;
			termination_on_q     <= 1'b0;
			receiver_on_q        <= 1'b0;
		end else if (ce) begin
			// Driver active only in Normal, battery good, no time-out
			lin_drive_q <= (mode_d == `LTMC_MODE_NORMAL) & ~txd
				& ~dom_lock_q & ~bat_low & ~res_hold_q;
			undervoltage_reset_n <= ~res_hold_q & bat;
			vcc_enable_q  <= bat & (mode_d != `LTMC_MODE_SLEEP);
			rxd_oe_q      <= bat;
			termination_on_q <= (mode_d == `LTMC_MODE_NORMAL) |
				(mode_d == `LTMC_MODE_FAILSAFE) | prewake;
			receiver_on_q <= (mode_d == `LTMC_MODE_NORMAL) | prewake;
			case (mode_d)
			`LTMC_MODE_NORMAL:   rxd_out_q <= lin;
			`LTMC_MODE_SILENT:   rxd_out_q <= 1'b1;
			`LTMC_MODE_FAILSAFE: rxd_out_q <= ~(wake_flag_q | wake_req);
			default:             rxd_out_q <= 1'b0;
			endcase
		end
	end

endmodule

// file: test/ltmc_core_monitor.sv
`timescale 1ns/10ps
`include "ltmc_regs.vh"
// ==========================================================
// Port checker for the mode control core
module ltmc_core_monitor #(
	parameter DOM_CYC   = 200,
	parameter RESET_CYC = 100
) (
	input wire       clk,
	input wire       rst_n,
	input wire       ce,
	input wire       txd_in,
	input wire       en_in,
	input wire       lin_in,
	input wire       battery_supply,
	input wire       battery_low,
	input wire       vcc_good,
	input wire       prewake_threshold,
	input wire       lin_drive_q,
	input wire       rxd_out_q,
	input wire       rxd_oe_q,
	input wire       undervoltage_reset_n,
	input wire       vcc_enable_q,
	input wire       termination_on_q,
	input wire       receiver_on_q,
	input wire       wake_flag_q,
	input wire [2:0] mode_q
);
	reg [15:0] dom_q;
	reg [15:0] good_q;
	// Run lengths; good_q saturates so a long run never wraps into a false failure, dom_q wraps
	always @(posedge clk) begin
		if (!rst_n) begin
			dom_q  <= 16'h0000;
			good_q <= 16'h0000;
		end else begin
			dom_q  <= lin_drive_q ? dom_q + 16'h0001 : 16'h0000;
			good_q <= !vcc_good ? 16'h0000 : good_q + {15'h0000, good_q != 16'hFFFF};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_low_batt_off: assert property (battery_low [*4] |-> !lin_drive_q)
		else $error("driver on with low battery");
	chk_uv_reset: assert property (!vcc_good [*8] |=> !undervoltage_reset_n)
		else $error("reset output high under undervoltage");
	chk_reset_hold: assert property ($rose(undervoltage_reset_n) |-> good_q >= RESET_CYC)
		else $error("reset released too early");
	chk_tx_source: assert property (lin_drive_q |-> !$past(txd_in, 3))
		else $error("driver on without transmit low");
	chk_dom_limit: assert property (dom_q <= DOM_CYC + 1)
		else $error("driver held past time-out");
	chk_rxd_mirror: assert property (mode_q == `LTMC_MODE_NORMAL && $past(mode_q) == `LTMC_MODE_NORMAL
		|-> rxd_out_q == $past(lin_in, 3))
		else $error("receive output does not follow bus");
	chk_silent_quiet: assert property (mode_q == `LTMC_MODE_SILENT |-> !lin_drive_q && rxd_out_q)
		else $error("silent mode not quiet");
	chk_sleep_reg: assert property (mode_q == `LTMC_MODE_SLEEP |-> !vcc_enable_q && !lin_drive_q)
		else $error("regulator or driver on in sleep");
	chk_failsafe_off: assert property (mode_q == `LTMC_MODE_FAILSAFE |-> !lin_drive_q)
		else $error("driver on in fail-safe");
	chk_reset_mode: assert property (!undervoltage_reset_n && $past(!undervoltage_reset_n)
		|-> mode_q != `LTMC_MODE_NORMAL)
		else $error("normal mode during reset");
	cover property (mode_q == `LTMC_MODE_SILENT);
	cover property (mode_q == `LTMC_MODE_SLEEP);
	cover property ($rose(wake_flag_q));
	cover property ($fell(lin_drive_q) && !txd_in);
endmodule

bind ltmc_core ltmc_core_monitor #(.DOM_CYC(DOM_CYC), .RESET_CYC(RESET_CYC)) mon (.*);

// file: test/ltmc_mcu_model.sv
`timescale 1ns/10ps
// ==========================================================
// Controller driving transmit and enable
module ltmc_mcu_model (
	input  wire clk,
	input  wire want_txd,
	input  wire want_en,
	output reg  txd_in = 1'b0,
	output reg  en_in = 1'b0
);
	// Transmit never moves in the cycle enable moves, so the mode select sees a steady level
	always @(negedge clk) begin
		en_in  <= want_en;
		txd_in <= (want_en != en_in) ? txd_in : want_txd;
	end
endmodule

// file: test/lin_transceiver_mode_control_test.sv
`timescale 1ns/10ps
`include "ltmc_regs.vh"
// ==========================================================
// Bench for the mode control core
module lin_transceiver_mode_control_test;
	localparam DOM = 200;
	reg        clk = 1'b0;
	reg        rst_n = 1'b0;
	reg        ce = 1'b1;
	reg        lin_in = 1'b1;
	reg        battery_supply = 1'b1;
	reg        battery_low = 1'b0;
	reg        vcc_good = 1'b1;
	reg        prewake_threshold = 1'b0;
	reg        want_txd = 1'b0;
	reg        want_en = 1'b0;
	wire       txd_in;
	wire       en_in;
	wire       lin_drive_q;
	wire       rxd_out_q;
	wire       rxd_oe_q;
	wire       undervoltage_reset_n;
	wire       vcc_enable_q;
	wire       termination_on_q;
	wire       receiver_on_q;
	wire       wake_flag_q;
	wire [2:0] mode_q;
	integer    n_errors = 0;
	integer    checked = 0;
	integer    j;
	reg  [3:0] rows [0:3];
	ltmc_core #(.DOM_CYC(DOM), .RESET_CYC(100)) uut (.*);
	ltmc_mcu_model mcu (.*);
	always #50 clk = ~clk;
	// ==========================================================
	// Helpers
	task chk(input [2:0] got, input [2:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task end_of_test;
		begin
			$display("checked=%0d n_errors=%0d", checked, n_errors);
			if (n_errors == 0 && checked > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Bounded wait for the reset output to let go
	task wait_res;
		integer i;
		begin
			for (i = 0; i < 400 && undervoltage_reset_n !== 1'b1; i = i + 1)
				cyc(1);
			if (i == 400) begin
				n_errors = n_errors + 1;
				end_of_test;
			end
		end
	endtask
	// ==========================================================
	// Main sequence; rows are transmit, bus, driver, receive
	initial begin
		rows[0] = 4'h2;
		rows[1] = 4'hD;
		rows[2] = 4'h8;
		rows[3] = 4'h7;
		cyc(12);
		rst_n <= 1'b1;
		cyc(20);
		chk(lin_drive_q, 3'h0);
		wait_res;
		chk(mode_q, `LTMC_MODE_FAILSAFE);
		chk(vcc_enable_q, 3'h1);
		want_txd <= 1'b1;
		cyc(2);
		want_en <= 1'b1;
		cyc(6);
		chk(mode_q, `LTMC_MODE_NORMAL);
		$display("power-up done");
		for (j = 0; j < 4; j = j + 1) begin
			want_txd <= rows[j][3];
			lin_in <= rows[j][2];
			cyc(6);
			chk(lin_drive_q, rows[j][1]);
			chk(rxd_out_q, rows[j][0]);
		end
		$display("normal table done");
		// Transmit is still low: hold through the time-out, then re-arm short and long
		cyc(DOM - 20);
		chk(lin_drive_q, 3'h1);
		cyc(30);
		chk(lin_drive_q, 3'h0);
		want_txd <= 1'b1;
		cyc(`LTMC_REACT_CYC / 2);
		want_txd <= 1'b0;
		cyc(6);
		chk(lin_drive_q, 3'h0);
		want_txd <= 1'b1;
		cyc(`LTMC_REACT_CYC + 10);
		want_txd <= 1'b0;
		cyc(6);
		chk(lin_drive_q, 3'h1);
		battery_low <= 1'b1;
		cyc(6);
		chk(lin_drive_q, 3'h0);
		battery_low <= 1'b0;
		want_txd <= 1'b1;
		$display("time-out done");
		// Enter silent with the bus dominant, then a short and a long wake pulse
		lin_in <= 1'b0;
		cyc(6);
		want_en <= 1'b0;
		cyc(6);
		chk(mode_q, `LTMC_MODE_SILENT);
		chk(vcc_enable_q, 3'h1);
		lin_in <= 1'b1;
		cyc(6);
		lin_in <= 1'b0;
		cyc(`LTMC_WAKE_CYC / 3);
		lin_in <= 1'b1;
		cyc(6);
		chk(mode_q, `LTMC_MODE_SILENT);
		lin_in <= 1'b0;
		prewake_threshold <= 1'b1;
		cyc(6);
		chk(receiver_on_q, 3'h1);
		chk(termination_on_q, 3'h1);
		cyc(`LTMC_WAKE_CYC + 40);
		lin_in <= 1'b1;
		prewake_threshold <= 1'b0;
		cyc(6);
		chk(mode_q, `LTMC_MODE_FAILSAFE);
		chk(rxd_out_q, 3'h0);
		chk(wake_flag_q, 3'h1);
		want_en <= 1'b1;
		cyc(6);
		chk(mode_q, `LTMC_MODE_NORMAL);
		$display("silent wake done");
		vcc_good <= 1'b0;
		cyc(10);
		chk(undervoltage_reset_n, 3'h0);
		chk(mode_q, `LTMC_MODE_FAILSAFE);
		vcc_good <= 1'b1;
		cyc(50);
		chk(mode_q, `LTMC_MODE_FAILSAFE);
		wait_res;
		cyc(6);
		chk(mode_q, `LTMC_MODE_NORMAL);
		$display("undervoltage done");
		want_txd <= 1'b0;
		cyc(3);
		want_en <= 1'b0;
		cyc(6);
		chk(mode_q, `LTMC_MODE_SLEEP);
		chk(vcc_enable_q, 3'h0);
		// Clock enable low freezes the mode even though enable rises
		ce <= 1'b0;
		want_en <= 1'b1;
		cyc(10);
		chk(mode_q, `LTMC_MODE_SLEEP);
		chk(vcc_enable_q, 3'h0);
		ce <= 1'b1;
		cyc(8);
		chk(mode_q, `LTMC_MODE_NORMAL);
		$display("clock enable freeze done");
		battery_supply <= 1'b0;
		cyc(6);
		chk(rxd_oe_q, 3'h0);
		$display("sleep and unpowered done");
		end_of_test;
	end
endmodule
